//--- pfi_defs.vh
// register map, field positions and reset values of the fault interrupt block
`ifndef PFI_DEFS_VH
`define PFI_DEFS_VH

// apb address width: index 16'h4022 * 4 needs 17 bits
`define PFI_AW              17
// width of the register index carried in paddr[16:2]
`define PFI_IDX_W           15

// register indices, byte address is four times the index
`define PFI_IDX_MEM_STAT    15'h4012
`define PFI_IDX_LIN_STAT    15'h4013
`define PFI_IDX_CONV_STAT   15'h4014
`define PFI_IDX_MEM_MASK    15'h401A
`define PFI_IDX_LIN_MASK    15'h401B
`define PFI_IDX_CONV_MASK   15'h401C
// summary interrupt status, mask and raw level view
`define PFI_IDX_SUM_STAT    15'h4020
`define PFI_IDX_SUM_MASK    15'h4021
`define PFI_IDX_LEVEL       15'h4022

// field positions in the memory event registers
`define PFI_MEM_DONE_BIT    5
`define PFI_MEM_FAIL_BIT    4
// field positions in the converter event registers
`define PFI_BUCK2_OC_BIT    9
`define PFI_BUCK1_OC_BIT    8
`define PFI_BUCK_UV_MSB     3
`define PFI_BUCK_UV_LSB     0
// field positions in the regulator undervoltage registers
`define PFI_LIN_UV_MSB      9
`define PFI_LIN_UV_LSB      0

// field positions in the summary registers
`define PFI_SUM_MEM_BIT     0
`define PFI_SUM_OC_BIT      1
`define PFI_SUM_UV_BIT      2

// reset values: every mask starts set
`define PFI_MEM_MASK_RST    2'h3
`define PFI_LIN_MASK_RST    10'h3FF
`define PFI_CONV_MASK_RST   6'h3F
`define PFI_SUM_MASK_RST    3'h7

`endif

//--- pfi_edge_flag.v
// synchronised rising-edge detector feeding sticky write-one-to-clear flags
`timescale 1ns/10ps

module pfi_edge_flag #(
  parameter W = 1                 // number of event sources
) (
  input  wire         sys_clk,    // core clock
  input  wire         srst,       // synchronous reset, active high
  input  wire [W-1:0] evt_in,     // raw event levels from other domains
  input  wire [W-1:0] clr,        // one-cycle clear request per flag
  output reg  [W-1:0] flag,       // sticky event flags
  output wire [W-1:0] level       // synchronised event levels
);

  reg [W-1:0] sync1;              // first stage, read only by sync2
  reg [W-1:0] sync2;              // second stage, safe to use
  reg [W-1:0] prev;               // last synchronised level
  wire [W-1:0] rise;              // one-cycle rising-edge pulse

  assign level = sync2;
  assign rise  = sync2 & ~prev;

  // two-flop synchroniser, then a delay stage for edge detection
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      sync1 <= {W{1'b0}};
      sync2 <= {W{1'b0}};
      prev  <= {W{1'b0}};
    end
    else
    begin
      sync1 <= evt_in;
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  // sticky flags: an edge in the clearing cycle wins over the clear
  always @(posedge sys_clk)
  begin
    if (srst)
      flag <= {W{1'b0}};
    else
      flag <= rise | (flag & ~clr);
  end

endmodule // pfi_edge_flag

//--- pfi_irq_aggregator.v
// fault interrupt status, masking and primary lines behind an apb slave
//
// Contract
// - memory command done edge sets bit 5
// - memory command fail edge sets bit 4
// - buck two overcurrent edge sets bit 9
// - buck one overcurrent edge sets bit 8
// - ten regulator undervoltage flags, bits 9..0
// - four buck undervoltage flags, bits 3..0
// - status stays set until one written (summary status is cleared by a read instead)
// - mask bit one blocks flag, same position
// - every mask bit resets to one
// - status sets regardless of mask state
// - memory line: either memory flag unmasked
// - overcurrent line: either buck flag unmasked
// - undervoltage line: any of fourteen unmasked
`timescale 1ns/10ps
`include "pfi_defs.vh"

module pfi_irq_aggregator (
  input  wire                 sys_clk,
  input  wire                 srst,
  // apb slave
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [`PFI_AW-1:0]   paddr,
  input  wire [31:0]          pwdata,
  input  wire [3:0]           pstrb,
  output wire                 pready,
  output reg  [31:0]          prdata,
  output wire                 pslverr,
  // event sources, asynchronous to sys_clk
  input  wire                 memory_cmd_done_evt,
  input  wire                 memory_cmd_fail_evt,
  input  wire                 buck2_overcurrent_evt,
  input  wire                 buck1_overcurrent_evt,
  input  wire [9:0]           linreg_undervolt_evt,
  input  wire [3:0]           buck_undervolt_evt,
  // primary lines and summary interrupt
  output wire                 memory_cmd_primary_irq,
  output wire                 overcurrent_primary_irq,
  output wire                 undervoltage_primary_irq,
  output wire                 summary_irq
);

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------

  wire [`PFI_IDX_W-1:0] idx;      // register index from the word address
  wire                  setup;    // first cycle of a transfer
  wire                  acc;      // access phase, always completes
  wire                  wr_go;    // write takes effect this edge
  wire                  rd_go;    // read completes this edge
  wire [15:0]           lane_en;  // per-bit enable from the byte strobes
  wire [15:0]           wdat;     // write data gated by the strobes

  // one select per mapped register
  wire sel_mem_stat;
  wire sel_lin_stat;
  wire sel_conv_stat;
  wire sel_mem_mask;
  wire sel_lin_mask;
  wire sel_conv_mask;
  wire sel_sum_stat;
  wire sel_sum_mask;
  wire sel_level;
  wire hit;                       // address maps to a register

  // low two address bits are ignored, every register is one word
  assign idx = paddr[`PFI_AW-1:2];

  assign sel_mem_stat  = (idx == `PFI_IDX_MEM_STAT);
  assign sel_lin_stat  = (idx == `PFI_IDX_LIN_STAT);
  assign sel_conv_stat = (idx == `PFI_IDX_CONV_STAT);
  assign sel_mem_mask  = (idx == `PFI_IDX_MEM_MASK);
  assign sel_lin_mask  = (idx == `PFI_IDX_LIN_MASK);
  assign sel_conv_mask = (idx == `PFI_IDX_CONV_MASK);
  assign sel_sum_stat  = (idx == `PFI_IDX_SUM_STAT);
  assign sel_sum_mask  = (idx == `PFI_IDX_SUM_MASK);
  assign sel_level     = (idx == `PFI_IDX_LEVEL);

  assign hit = sel_mem_stat | sel_lin_stat | sel_conv_stat |
               sel_mem_mask | sel_lin_mask | sel_conv_mask |
               sel_sum_stat | sel_sum_mask | sel_level;

  assign setup = psel & ~penable;
  assign acc   = psel & penable;

  // zero wait states: read data is already registered in setup
  assign pready  = 1'b1;
  // unmapped addresses answer with an error and are otherwise ignored
  assign pslverr = acc & ~hit;

  // only mapped registers are ever touched
  assign wr_go = acc & pwrite & hit;
  assign rd_go = acc & ~pwrite & hit;

  // only the low two lanes carry register bits
  assign lane_en = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign wdat    = pwdata[15:0] & lane_en;

  // ---------------------------------------------------------------
  // event flags
  // ---------------------------------------------------------------

  wire [1:0] mem_flag;            // {done, fail}
  wire [9:0] lin_flag;            // regulator undervoltage flags
  wire [5:0] conv_flag;           // {buck2 oc, buck1 oc, buck uv[3:0]}
  wire [1:0] mem_lvl;             // synchronised levels, same layout
  wire [9:0] lin_lvl;
  wire [5:0] conv_lvl;
  wire [1:0] mem_clr;             // write-one-to-clear requests
  wire [9:0] lin_clr;
  wire [5:0] conv_clr;

  // a written one clears, a written zero leaves the flag alone
  assign mem_clr = {2{wr_go & sel_mem_stat}} &
                   {wdat[`PFI_MEM_DONE_BIT],
                    wdat[`PFI_MEM_FAIL_BIT]};
  assign lin_clr = {10{wr_go & sel_lin_stat}} &
                   wdat[`PFI_LIN_UV_MSB:`PFI_LIN_UV_LSB];
  assign conv_clr = {6{wr_go & sel_conv_stat}} &
                    {wdat[`PFI_BUCK2_OC_BIT],
                     wdat[`PFI_BUCK1_OC_BIT],
                     wdat[`PFI_BUCK_UV_MSB:`PFI_BUCK_UV_LSB]};

  // memory command completion and failure; the mask is not consulted
  pfi_edge_flag #(
    .W       (2)
  ) u_mem_flags (
    .sys_clk (sys_clk),
    .srst    (srst),
    .evt_in  ({memory_cmd_done_evt, memory_cmd_fail_evt}),
    .clr     (mem_clr),
    .flag    (mem_flag),
    .level   (mem_lvl)
  );

  // one flag per linear regulator
  pfi_edge_flag #(
    .W       (10)
  ) u_lin_flags (
    .sys_clk (sys_clk),
    .srst    (srst),
    .evt_in  (linreg_undervolt_evt),
    .clr     (lin_clr),
    .flag    (lin_flag),
    .level   (lin_lvl)
  );

  // converter overcurrent and undervoltage share one register
  pfi_edge_flag #(
    .W       (6)
  ) u_conv_flags (
    .sys_clk (sys_clk),
    .srst    (srst),
    .evt_in  ({buck2_overcurrent_evt, buck1_overcurrent_evt,
               buck_undervolt_evt}),
    .clr     (conv_clr),
    .flag    (conv_flag),
    .level   (conv_lvl)
  );

  // ---------------------------------------------------------------
  // mask registers
  // ---------------------------------------------------------------

  reg [1:0] mem_mask;             // {done, fail} masks
  reg [9:0] lin_mask;             // regulator undervoltage masks
  reg [5:0] conv_mask;            // converter masks, flag layout
  reg [2:0] sum_mask;             // summary interrupt masks

  // masks start set so nothing reaches a line until software opens it
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      mem_mask  <= `PFI_MEM_MASK_RST;
      lin_mask  <= `PFI_LIN_MASK_RST;
      conv_mask <= `PFI_CONV_MASK_RST;
      sum_mask  <= `PFI_SUM_MASK_RST;
    end
    else if (wr_go)
    begin
      // bits whose byte lane is not strobed keep their value
      if (sel_mem_mask)
      begin
        if (lane_en[`PFI_MEM_DONE_BIT])
          mem_mask[1] <= pwdata[`PFI_MEM_DONE_BIT];
        if (lane_en[`PFI_MEM_FAIL_BIT])
          mem_mask[0] <= pwdata[`PFI_MEM_FAIL_BIT];
      end
      if (sel_lin_mask)
      begin
        if (lane_en[8])
          lin_mask[9:8] <= pwdata[9:8];
        if (lane_en[0])
          lin_mask[7:0] <= pwdata[7:0];
      end
      if (sel_conv_mask)
      begin
        if (lane_en[`PFI_BUCK2_OC_BIT])
          conv_mask[5:4] <= {pwdata[`PFI_BUCK2_OC_BIT],
                             pwdata[`PFI_BUCK1_OC_BIT]};
        if (lane_en[`PFI_BUCK_UV_LSB])
          conv_mask[3:0] <=
            pwdata[`PFI_BUCK_UV_MSB:`PFI_BUCK_UV_LSB];
      end
      if (sel_sum_mask && lane_en[0])
        sum_mask <= pwdata[2:0];
    end
  end

  // ---------------------------------------------------------------
  // primary lines
  // ---------------------------------------------------------------

  wire [1:0] mem_live;            // flags both set and unmasked
  wire [9:0] lin_live;
  wire [5:0] conv_live;

  // a set mask bit blocks its flag at the same position
  assign mem_live  = mem_flag & ~mem_mask;
  assign lin_live  = lin_flag & ~lin_mask;
  assign conv_live = conv_flag & ~conv_mask;

  // pure or of live flags, so a clear or a mask drops the line
  // in the same cycle; no extra state to fall out of step
  assign memory_cmd_primary_irq   = |mem_live;
  assign overcurrent_primary_irq  = |conv_live[5:4];
  assign undervoltage_primary_irq = |lin_live |
                                    |conv_live[3:0];

  // ---------------------------------------------------------------
  // summary interrupt: sticky rise of each primary line
  // ---------------------------------------------------------------

  wire [2:0] prim;                // current primary lines
  reg  [2:0] prim_q;              // primary lines one cycle ago
  reg  [2:0] sum_flag;            // sticky summary status
  wire [2:0] sum_clr;             // bits cleared by a completed read

  assign prim = {undervoltage_primary_irq, overcurrent_primary_irq,
                 memory_cmd_primary_irq};

  // only bits actually returned to software are cleared, so a rise
  // between setup and access is not lost
  assign sum_clr = {3{rd_go & sel_sum_stat}} & prdata[2:0];

  // summary status: new rises win over the read clear
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      prim_q   <= 3'h0;
      sum_flag <= 3'h0;
    end
    else
    begin
      prim_q   <= prim;
      sum_flag <= (prim & ~prim_q) | (sum_flag & ~sum_clr);
    end
  end

  assign summary_irq = |(sum_flag & ~sum_mask);

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------

  reg [15:0] rd_mux;              // selected register, reserved bits 0

  // register views; unused positions read as zero
  always @*
  begin
    rd_mux = 16'h0000;
    if (sel_mem_stat)
    begin
      rd_mux[`PFI_MEM_DONE_BIT] = mem_flag[1];
      rd_mux[`PFI_MEM_FAIL_BIT] = mem_flag[0];
    end
    else if (sel_lin_stat)
      rd_mux[`PFI_LIN_UV_MSB:`PFI_LIN_UV_LSB] = lin_flag;
    else if (sel_conv_stat)
    begin
      rd_mux[`PFI_BUCK2_OC_BIT] = conv_flag[5];
      rd_mux[`PFI_BUCK1_OC_BIT] = conv_flag[4];
      rd_mux[`PFI_BUCK_UV_MSB:`PFI_BUCK_UV_LSB] = conv_flag[3:0];
    end
    else if (sel_mem_mask)
    begin
      rd_mux[`PFI_MEM_DONE_BIT] = mem_mask[1];
      rd_mux[`PFI_MEM_FAIL_BIT] = mem_mask[0];
    end
    else if (sel_lin_mask)
      rd_mux[`PFI_LIN_UV_MSB:`PFI_LIN_UV_LSB] = lin_mask;
    else if (sel_conv_mask)
    begin
      rd_mux[`PFI_BUCK2_OC_BIT] = conv_mask[5];
      rd_mux[`PFI_BUCK1_OC_BIT] = conv_mask[4];
      rd_mux[`PFI_BUCK_UV_MSB:`PFI_BUCK_UV_LSB] = conv_mask[3:0];
    end
    else if (sel_sum_stat)
      rd_mux[2:0] = sum_flag;
    else if (sel_sum_mask)
      rd_mux[2:0] = sum_mask;
    else if (sel_level)
      // raw synchronised levels: memory in 15:14, converters in 13:8
      // in flag layout, regulators one to eight in 7:0; the last two
      // regulators do not fit in the sixteen-bit view
      rd_mux = {mem_lvl, conv_lvl, lin_lvl[7:0]};
  end

  // read data captured in setup; held until the next setup so the
  // summary clear can use exactly what software saw
  always @(posedge sys_clk)
  begin
    if (srst)
      prdata <= 32'h00000000;
    else if (setup)
    begin
      if (pwrite)
        prdata <= 32'h00000000;
      else
        prdata <= {16'h0000, rd_mux};
    end
  end

endmodule // pfi_irq_aggregator

//--- pfi_irq_aggregator_sva.sv
// port-level checker of the fault interrupt block, bound to its top
`timescale 1ns/10ps
`include "pfi_defs.vh"

module pfi_irq_checker (
  input wire               sys_clk,
  input wire               srst,
  input wire               psel,
  input wire               penable,
  input wire               pwrite,
  input wire [`PFI_AW-1:0] paddr,
  input wire [31:0]        pwdata,
  input wire [3:0]         pstrb,
  input wire               pready,
  input wire [31:0]        prdata,
  input wire               pslverr,
  input wire               memory_cmd_done_evt,
  input wire               memory_cmd_fail_evt,
  input wire               buck2_overcurrent_evt,
  input wire               buck1_overcurrent_evt,
  input wire [9:0]         linreg_undervolt_evt,
  input wire [3:0]         buck_undervolt_evt,
  input wire               memory_cmd_primary_irq,
  input wire               overcurrent_primary_irq,
  input wire               undervoltage_primary_irq,
  input wire               summary_irq
);
  wire        wr_acc = psel & penable & pwrite;  // edge where a write lands
  wire [14:0] idx    = paddr[16:2];              // word index
  wire [15:0] lane   = {{8{pstrb[1]}}, {8{pstrb[0]}}};  // strobed bits
  reg  [15:0] mem_msk;   // shadow of the memory mask
  reg  [15:0] conv_msk;  // shadow of the converter mask

  // shadow masks let an event edge be judged without seeing inside
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      mem_msk  <= 16'hFFFF;
      conv_msk <= 16'hFFFF;
    end
    else if (wr_acc && idx == `PFI_IDX_MEM_MASK)
      mem_msk  <= (mem_msk & ~lane) | (pwdata[15:0] & lane);
    else if (wr_acc && idx == `PFI_IDX_CONV_MASK)
      conv_msk <= (conv_msk & ~lane) | (pwdata[15:0] & lane);
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  reset_lines_low_a: assert property (
    $fell(srst) |-> !(memory_cmd_primary_irq | overcurrent_primary_irq
    | undervoltage_primary_irq)) else $error("line high after reset");
  done_edge_line_a: assert property (
    $rose(memory_cmd_done_evt) && !mem_msk[5] && !wr_acc ##1 (!wr_acc)[*2]
    |=> memory_cmd_primary_irq) else $error("done edge missed");
  buck1_edge_line_a: assert property (
    $rose(buck1_overcurrent_evt) && !conv_msk[8] && !wr_acc ##1
    (!wr_acc)[*2] |=> overcurrent_primary_irq) else $error("buck1 missed");
  mem_rise_cause_a: assert property (
    $rose(memory_cmd_primary_irq) |-> $past(wr_acc) || mem_msk[5:4] != 2'h3)
    else $error("memory line rose while masked");
  oc_rise_cause_a: assert property (
    $rose(overcurrent_primary_irq) |-> $past(wr_acc)
    || conv_msk[9:8] != 2'h3) else $error("overcurrent line rose masked");
  uv_rise_cause_a: assert property (
    $rose(undervoltage_primary_irq) |-> $past(wr_acc) || $past(
    |{linreg_undervolt_evt, buck_undervolt_evt}, 3)) else $error("uv rise");
  line_fall_cause_a: assert property (
    $fell(memory_cmd_primary_irq) || $fell(overcurrent_primary_irq)
    || $fell(undervoltage_primary_irq) |-> $past(wr_acc))
    else $error("primary line fell without a write");
  unmapped_read_a: assert property (
    psel && penable && !pwrite && idx == 15'h4015 |-> pslverr
    && prdata == 32'h0) else $error("unmapped read not refused");
  error_phase_a: assert property (
    pslverr |-> psel && penable) else $error("error outside access");
endmodule // pfi_irq_checker

bind pfi_irq_aggregator pfi_irq_checker chk_u (
  .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .memory_cmd_done_evt(memory_cmd_done_evt),
  .memory_cmd_fail_evt(memory_cmd_fail_evt),
  .buck2_overcurrent_evt(buck2_overcurrent_evt),
  .buck1_overcurrent_evt(buck1_overcurrent_evt),
  .linreg_undervolt_evt(linreg_undervolt_evt),
  .buck_undervolt_evt(buck_undervolt_evt),
  .memory_cmd_primary_irq(memory_cmd_primary_irq),
  .overcurrent_primary_irq(overcurrent_primary_irq),
  .undervoltage_primary_irq(undervoltage_primary_irq),
  .summary_irq(summary_irq));

//--- pfi_irq_aggregator_tb_top.sv
// self-checking bench of the fault interrupt block over apb
`timescale 1ns/10ps
`include "pfi_defs.vh"

module pfi_irq_aggregator_tb_top;
  logic               sys_clk = 1'b0;  // 10 mhz core clock
  logic               srst = 1'b1;     // held for six cycles
  logic               psel = 1'b0;     // apb request
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [`PFI_AW-1:0] paddr = '0;
  logic [31:0]        pwdata = '0;
  logic [3:0]         pstrb = 4'hF;
  logic [17:0]        ev = '0;  // done, fail, oc2, oc1, buck uv, lin uv
  wire                pready;
  wire                pslverr;
  wire  [31:0]        prdata;
  wire  [3:0]         irq;      // memory, overcurrent, uv, summary
  logic [31:0]        rdat;     // data taken at the answering edge
  logic               rerr;
  int                 n_mismatch = 0;
  int                 samples_checked = 0;

  // half period of 50 ns
  always #50 sys_clk = ~sys_clk;

  pfi_irq_aggregator dut_u (
    .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .memory_cmd_done_evt(ev[17]), .memory_cmd_fail_evt(ev[16]),
    .buck2_overcurrent_evt(ev[15]), .buck1_overcurrent_evt(ev[14]),
    .buck_undervolt_evt(ev[13:10]), .linreg_undervolt_evt(ev[9:0]),
    .memory_cmd_primary_irq(irq[3]), .overcurrent_primary_irq(irq[2]),
    .undervoltage_primary_irq(irq[1]), .summary_irq(irq[0]));

  task automatic conclude();
    $display("compared %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer, entered and left just after a rising edge
  task automatic apb(input logic wr, input logic [14:0] idx,
                     input logic [31:0] wd, input logic [3:0] st);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    pstrb <= st;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 40);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
    if (n >= 40)
    begin
      n_mismatch++;
      conclude();
    end
  endtask

  task automatic rd(input logic [14:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0, 4'hF);
    chk(rdat, exp);
  endtask

  task automatic wr(input logic [14:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d, 4'hF);
  endtask

  // the summary bit moves one edge after its line, so look mid-cycle
  // once every flop has settled, then hand back on a rising edge
  task automatic lchk(input logic [3:0] e);
    @(negedge sys_clk);
    chk({28'h0, irq}, {28'h0, e});
    @(posedge sys_clk);
  endtask

  // event level held two cycles, then time for the flag to land
  task automatic pulse(input logic [17:0] v);
    ev <= v;
    repeat (2) @(posedge sys_clk);
    ev <= '0;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic t_reset();
    rd(`PFI_IDX_MEM_STAT, 32'h0);
    rd(`PFI_IDX_LIN_STAT, 32'h0);
    rd(`PFI_IDX_CONV_STAT, 32'h0);
    rd(`PFI_IDX_MEM_MASK, 32'h30);
    rd(`PFI_IDX_LIN_MASK, 32'h3FF);
    rd(`PFI_IDX_CONV_MASK, 32'h30F);
    rd(`PFI_IDX_SUM_MASK, 32'h7);
    lchk(4'h0);
    rd(15'h4015, 32'h0);
    chk({31'h0, rerr}, 32'h1);
  endtask

  task automatic t_mem();
    pulse(18'h20000);
    rd(`PFI_IDX_MEM_STAT, 32'h20);
    lchk(4'h0);
    wr(`PFI_IDX_SUM_MASK, 32'h6);
    wr(`PFI_IDX_MEM_MASK, 32'h10);
    lchk(4'h9);
    rd(`PFI_IDX_SUM_STAT, 32'h1);
    wr(`PFI_IDX_MEM_STAT, 32'h0);
    rd(`PFI_IDX_MEM_STAT, 32'h20);
    wr(`PFI_IDX_MEM_STAT, 32'h20);
    lchk(4'h0);
    pulse(18'h20000);
    lchk(4'h9);
    rd(`PFI_IDX_SUM_STAT, 32'h1);
    pulse(18'h10000);
    rd(`PFI_IDX_MEM_STAT, 32'h30);
    wr(`PFI_IDX_MEM_STAT, 32'h20);
    lchk(4'h0);
    wr(`PFI_IDX_MEM_MASK, 32'h0);
    lchk(4'h9);
    wr(`PFI_IDX_MEM_MASK, 32'h30);
    lchk(4'h1);
    rd(`PFI_IDX_SUM_STAT, 32'h1);
    wr(`PFI_IDX_MEM_STAT, 32'h10);
    rd(`PFI_IDX_MEM_STAT, 32'h0);
  endtask

  task automatic t_conv();
    pulse(18'h0C000);
    rd(`PFI_IDX_CONV_STAT, 32'h300);
    lchk(4'h0);
    apb(1'b1, `PFI_IDX_CONV_MASK, 32'h0, 4'h2);
    lchk(4'h4);
    rd(`PFI_IDX_CONV_MASK, 32'hF);
    wr(`PFI_IDX_CONV_STAT, 32'h100);
    lchk(4'h4);
    wr(`PFI_IDX_CONV_STAT, 32'h200);
    lchk(4'h0);
    pulse(18'h04000);
    lchk(4'h4);
    wr(`PFI_IDX_CONV_STAT, 32'h100);
    lchk(4'h0);
  endtask

  task automatic t_uv();
    for (int i = 0; i < 10; i++)
    begin
      pulse(18'h1 << i);
      rd(`PFI_IDX_LIN_STAT, (32'h1 << (i + 1)) - 32'h1);
    end
    for (int m = 0; m < 4; m++)
    begin
      pulse(18'h400 << m);
      rd(`PFI_IDX_CONV_STAT, (32'h1 << (m + 1)) - 32'h1);
    end
    lchk(4'h0);
    apb(1'b1, `PFI_IDX_LIN_MASK, 32'h0, 4'h2);
    lchk(4'h2);
    rd(`PFI_IDX_LIN_MASK, 32'hFF);
    wr(`PFI_IDX_LIN_STAT, 32'h300);
    lchk(4'h0);
    rd(`PFI_IDX_LIN_STAT, 32'hFF);
    wr(`PFI_IDX_CONV_MASK, 32'h307);
    lchk(4'h2);
    wr(`PFI_IDX_CONV_STAT, 32'hF);
    lchk(4'h0);
  endtask

  // raw level view while done, buck two overcurrent and regulator one
  // are held high; all three stay masked so no line may rise
  task automatic t_level();
    ev <= 18'h28001;
    repeat (2) @(posedge sys_clk);
    rd(`PFI_IDX_LEVEL, 32'hA001);
    ev <= '0;
    repeat (4) @(posedge sys_clk);
    rd(`PFI_IDX_MEM_STAT, 32'h20);
    lchk(4'h0);
  endtask

  // reset, then every scenario in turn
  initial
  begin
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_mem();
    t_conv();
    t_uv();
    t_level();
    conclude();
  end
endmodule // pfi_irq_aggregator_tb_top
